// ===== hdl/standby_timer.sv
// standby command handling and automatic power-down timer
// assumes command strobe, host access and spindle signals are on ref_clk
//
// Function
// - opcodes e2 and 96 both decode as the standby command
// - standby enters standby except during spin-up; every standby loads the timeout code
// - cached writes are flushed before the spindle stops
// - spindle spins down while the host interface stays ready
// - spindle already stopped skips the spin-down step
// - commands accepted in standby; media work waits for spin-up
// - countdown runs only in idle, never in standby
// - timeout code zero disables automatic power-down
// - nonzero code enables power-down with decoded interval
// - codes 1-240 times five, 241-251 half hours
// - codes 252 to 255 map to fixed special intervals
// - expiry without host access enters standby automatically
// - any host access reloads the full interval
`default_nettype none
`include "standby_defs.svh"
module standby_timer #(
  parameter int unsigned CLK_HZ = `CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] sector_count,
  input wire logic host_access,
  input wire logic cache_dirty,
  input wire logic flush_done,
  input wire logic spindle_stopped,
  input wire logic spindle_at_speed,
  input wire logic media_req,
  output logic flush_req,
  output logic spin_down_req,
  output logic spin_up_req,
  output logic media_go,
  output logic cmd_done,
  output logic in_standby,
  output logic [7:0] error_flags,
  output logic [7:0] drive_condition_flags
);
  standby_pkg::pwr_state_t state_q;
  standby_pkg::pwr_state_t state_d;
  logic [7:0] code_q;
  logic [31:0] sec_q;
  logic [31:0] sec_d;
  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic done_q;
  logic done_d;
  logic [31:0] interval_s;

  // command decode
  wire is_standby_op = cmd_code == `CMD_STANDBY ||
    cmd_code == `CMD_STANDBY_ALT;
  wire is_standby = cmd_valid && is_standby_op;
  wire other_cmd = cmd_valid && !is_standby_op;
  wire [7:0] new_code = is_standby ? sector_count : code_q;

  // state decode
  wire st_idle = state_q == standby_pkg::ST_IDLE;
  wire st_flush = state_q == standby_pkg::ST_FLUSH;
  wire st_spin_down = state_q == standby_pkg::ST_SPIN_DOWN;
  wire st_standby = state_q == standby_pkg::ST_STANDBY;
  wire st_spin_up = state_q == standby_pkg::ST_SPIN_UP;

  // timeout code classes
  wire code_off = code_q == `TMO_DISABLED;
  wire code_short = !code_off && code_q <= `TMO_SHORT_MAX;
  wire code_halfhr = code_q > `TMO_SHORT_MAX &&
    code_q <= `TMO_HALFHR_MAX;
  wire code_252 = code_q == `TMO_CODE_252;
  wire code_253 = code_q == `TMO_CODE_253;
  wire code_254 = code_q == `TMO_CODE_254;
  wire [7:0] halfhr_cnt = code_q - `TMO_SHORT_MAX;

  // interval in seconds
  wire [31:0] short_s = {24'h0, code_q} * `TMO_SHORT_STEP_S;
  wire [31:0] halfhr_s = {24'h0, halfhr_cnt} * `TMO_HALFHR_S;
  wire [31:0] special_s = code_252 ? `TMO_252_S :
    code_253 ? `TMO_253_S :
    code_254 ? `TMO_254_S : `TMO_255_S;
  assign interval_s = code_off ? 32'd0 :
    code_short ? short_s :
    code_halfhr ? halfhr_s : special_s;

  // timer control
  wire timer_en = !code_off;
  wire sec_tick = tick_q == CLK_HZ - 32'd1;
  // fire on the last tick, so n seconds take n ticks, not n plus one
  wire expired = timer_en && sec_q == 32'd1 && sec_tick;
  wire auto_down = expired && !host_access;
  wire wake = media_req || other_cmd;
  wire hold_timer = !st_idle || host_access || is_standby;
  wire hold_tick = sec_tick || !st_idle || host_access;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      standby_pkg::ST_IDLE: begin
        if (is_standby) begin
          state_d = standby_pkg::ST_FLUSH;
        end else if (auto_down) begin
          state_d = standby_pkg::ST_FLUSH;
        end
      end
      standby_pkg::ST_FLUSH: begin
        // no spindle stop while accepted writes are still cached
        if (!cache_dirty || flush_done) begin
          if (spindle_stopped) begin
            state_d = standby_pkg::ST_STANDBY;
          end else begin
            state_d = standby_pkg::ST_SPIN_DOWN;
          end
        end
      end
      standby_pkg::ST_SPIN_DOWN: begin
        if (spindle_stopped) begin
          state_d = standby_pkg::ST_STANDBY;
        end
      end
      standby_pkg::ST_STANDBY: begin
        if (wake) begin
          state_d = standby_pkg::ST_SPIN_UP;
        end
      end
      standby_pkg::ST_SPIN_UP: begin
        if (spindle_at_speed) begin
          state_d = standby_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = standby_pkg::ST_IDLE;
      end
    endcase
  end

  // countdown held full outside idle; reload on access
  always_comb begin
    sec_d = sec_q;
    if (hold_timer)
      sec_d = interval_s;
    else if (sec_tick && sec_q != 32'd0)
      sec_d = sec_q - 32'd1;
  end

  assign tick_d = hold_tick ? 32'd0 : tick_q + 32'd1;
  assign done_d = !st_standby && state_d == standby_pkg::ST_STANDBY;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= standby_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_q <= `TMO_DISABLED;
    end else begin
      code_q <= new_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_q <= 32'd0;
    end else begin
      sec_q <= sec_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_q <= 32'd0;
    end else begin
      tick_q <= tick_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  assign flush_req = st_flush && cache_dirty;
  assign spin_down_req = st_spin_down;
  assign spin_up_req = st_spin_up;
  // media work stalls until the spindle is back at speed
  assign media_go = media_req && st_idle && spindle_at_speed;
  assign cmd_done = done_q;
  assign in_standby = st_standby;
  assign error_flags = 8'h00;

  // status bits; interface stays ready in every state
  always_comb begin
    drive_condition_flags = 8'h00;
    drive_condition_flags[`ST_BSY] = 1'b0;
    drive_condition_flags[`ST_RDY] = 1'b1;
    drive_condition_flags[`ST_DSC] = !st_standby;
    drive_condition_flags[`ST_ERR] = 1'b0;
  end
endmodule
`default_nettype wire

// ===== shared/standby_defs.svh
// constants for the standby command and power-down timer block
// assumes one 125 MHz device clock and an 8-bit command interface
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
`define CMD_STANDBY 8'he2
`define CMD_STANDBY_ALT 8'h96
`define TMO_DISABLED 8'h00
`define TMO_SHORT_MAX 8'hf0
`define TMO_HALFHR_MAX 8'hfb
`define TMO_CODE_252 8'hfc
`define TMO_CODE_253 8'hfd
`define TMO_CODE_254 8'hfe
`define TMO_CODE_255 8'hff
`define TMO_SHORT_STEP_S 32'd5
`define TMO_HALFHR_S 32'd1800
`define TMO_252_S 32'd1260
`define TMO_253_S 32'd28800
`define TMO_254_S 32'd1270
`define TMO_255_S 32'd1275
`define CLK_HZ 32'd125000000
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_ERR 0
`define ER_ABT 2
`endif

// ===== shared/standby_pkg.sv
// types for the standby command and power-down timer block
// no dependencies
`default_nettype none
package standby_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FLUSH = 5'b00010,
    ST_SPIN_DOWN = 5'b00100,
    ST_STANDBY = 5'b01000,
    ST_SPIN_UP = 5'b10000
  } pwr_state_t;
endpackage
`default_nettype wire

// ===== sim/spindle_model.sv
// spindle and write cache stand-in
// slow holds a spin-up back
`default_nettype none
module spindle_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic wr_cached,
  input wire logic flush_req,
  input wire logic spin_down_req,
  input wire logic spin_up_req,
  output logic flush_done,
  output logic cache_dirty,
  output logic spindle_stopped,
  output logic spindle_at_speed
);
  timeunit 1ns;
  timeprecision 1ns;
  assign spindle_at_speed = !spindle_stopped;
  always_ff @(posedge ref_clk) begin
    flush_done <= flush_req & !flush_done;
    cache_dirty <= !rst & (wr_cached | cache_dirty & !flush_done);
    if (rst | spin_up_req & !slow) spindle_stopped <= 1'b0;
    else if (spin_down_req) spindle_stopped <= 1'b1;
  end
endmodule
`default_nettype wire

// ===== sim/standby_timer_asserts.sv
// port checker for the standby timer
// bound from the bench; one ref_clk domain
`default_nettype none
module standby_timer_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic media_req,
  input wire logic spindle_at_speed,
  input wire logic flush_req,
  input wire logic spin_down_req,
  input wire logic spin_up_req,
  input wire logic media_go,
  input wire logic cmd_done,
  input wire logic in_standby,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] drive_condition_flags
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_dn; $rose(in_standby) |-> cmd_done; endproperty
  a_dn: assert property (p_dn) else $error("dn");
  property p_df; drive_condition_flags == {3'h2, !in_standby, 4'h0};
  endproperty
  a_df: assert property (p_df) else $error("df");
  property p_fq; flush_req |-> !spin_down_req && !in_standby; endproperty
  a_fq: assert property (p_fq) else $error("fq");
  property p_go; media_go |-> spindle_at_speed && media_req; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_wk; in_standby && media_req |=> spin_up_req; endproperty
  a_wk: assert property (p_wk) else $error("wk");
  property p_up; $fell(spin_up_req) |-> $past(spindle_at_speed); endproperty
  a_up: assert property (p_up) else $error("up");
  property p_rs; $fell(rst) |-> !flush_req [*8]; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_er; error_flags == 8'h00; endproperty
  a_er: assert property (p_er) else $error("er");
  c_sb: cover property ($rose(in_standby));
  c_up: cover property ($fell(spin_up_req));
  c_go: cover property (media_go);
endmodule
`default_nettype wire

// ===== sim/test_standby_timer.sv
// bench for the standby timer
// a second is four cycles to keep runs short
`default_nettype none
module test_standby_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, cmd_valid = 0, host_access = 0, slow = 0;
  logic media_req = 0, wr_cached = 0, flush_done, cache_dirty, flush_req;
  logic spindle_stopped, spindle_at_speed, spin_down_req, spin_up_req;
  logic media_go, in_standby, cmd_done;
  logic [7:0] error_flags, drive_condition_flags;
  logic [7:0] cmd_code = 8'h00, sector_count = 8'h00;
  int errors = 0, checked = 0;
  standby_timer #(.CLK_HZ(4)) u_standby_timer (.*);
  spindle_model u_spindle_model (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task check(string n, logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task cmd(logic [7:0] c, s);
    {cmd_valid, cmd_code, sector_count} = {1'b1, c, s};
    tick(1);
    cmd_valid = 0;
  endtask
  task wt(logic v);
    for (int i = 0; i < 60 && in_standby !== v; i++) tick(1);
    check("sb", in_standby, v);
  endtask
  // wake, optional host traffic, then the timer must run out
  task timed(logic [7:0] c, int s, h);
    cmd(8'he2, c);
    wt(1);
    cmd(8'h25, 8'h00);
    host_access = 1;
    tick(h);
    host_access = 0;
    tick(s * 4 - 2);
    check("early", in_standby, 0);
    wt(1);
    $display("t %h", c);
  endtask
  initial begin
    tick(4);
    rst = 0;
    wr_cached = 1;
    tick(8);
    wr_cached = 0;
    check("sb", in_standby, 0);
    check("flags", drive_condition_flags, 8'h50);
    check("err", error_flags, 8'h00);
    cmd(8'h96, 8'h00);
    wt(1);
    check("done", cmd_done, 1);
    check("flags", drive_condition_flags, 8'h40);
    check("dirty", cache_dirty, 0);
    {slow, media_req} = 2'b11;
    tick(9);
    check("go", media_go, 0);
    slow = 0;
    tick(200);
    check("go", media_go, 1);
    media_req = 0;
    $display("t 00");
    timed(8'h01, 5, 0);
    timed(8'h02, 10, 30);
    timed(8'hf1, 1800, 0);
    timed(8'hfe, 1270, 0);
    final_report;
  end
  initial begin
    #250000;
    errors++;
    final_report;
  end
endmodule
bind standby_timer standby_timer_asserts u_chk (.*);
`default_nettype wire
